// ==== lwc_pkg.sv ====
package lwc_pkg;

    // ------------------------------------------------------------
    // Transfer geometry
    // ------------------------------------------------------------
    localparam int SECTOR_BYTES = 512;
    localparam int WORD_BYTES = 2;
    localparam int WORDS_PER_SECTOR = SECTOR_BYTES / WORD_BYTES;
    localparam int WIDX_W = $clog2(WORDS_PER_SECTOR);
    localparam int DATA_W = 8 * WORD_BYTES;
    localparam int LOG_W = 8;
    localparam int SEC_W = 16;
    localparam int ST_W = LOG_W + SEC_W + WIDX_W + DATA_W;

    // ------------------------------------------------------------
    // Opcodes and register fields
    // ------------------------------------------------------------
    localparam logic [7:0] OP_LOG_PIO = 8'h3f;
    localparam logic [7:0] OP_LOG_DMA = 8'h57;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_COR = 2;
    localparam int ST_ERR = 0;
    localparam int ER_ABT = 2;
    localparam logic [7:0] STAT_RESET = 8'h50;
    localparam logic [7:0] ERR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Log directory entry: size, read-only flag, feature enabled
    // ------------------------------------------------------------
    localparam int DIR_AW = 8;
    localparam int DIR_SIZE_W = 16;
    localparam int DIR_RO_BIT = 16;
    localparam int DIR_FEAT_BIT = 17;
    localparam int DIR_W = 18;

    typedef enum logic [2:0] {S_IDLE, S_LOOK, S_CHECK, S_XFER, S_FIN} lwc_state_e;

    function automatic logic [7:0] lwc_stat(input logic busy, input logic drq, input logic err);
        logic [7:0] s;
        s = 8'h00;
        s[ST_BSY] = busy;
        s[ST_RDY] = !busy;
        s[ST_DSC] = !busy;
        s[ST_DRQ] = drq;
        s[ST_ERR] = err;
        return s;
    endfunction

endpackage

// ==== lwc_if.sv ====
`timescale 1ns/100ps
interface lwc_strm_if #(parameter int W = 8);
    logic push;
    logic [W-1:0] din;
    logic room;
    logic empty;
    modport src (output push, output din, input room, input empty);
    modport snk (input push, input din, output room, output empty);
endinterface

interface lwc_dir_if #(parameter int AW = 8, parameter int DW = 18);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== lwc_buf.sv ====
`timescale 1ns/100ps
module lwc_buf import lwc_pkg::*; #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    lwc_strm_if.snk up,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0] cnt;
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic vld;
    } lwc_buf_s;

    lwc_buf_s q;
    lwc_buf_s d;
    logic pop;

    if (W < 1) begin : g_chk
        $error("lwc_buf: width must be positive");
    end

    // ------------------------------------------------------------
    // Two-entry queue, head always in e0
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        pop = q.vld && out_ready;
        if (pop) begin
            if (q.cnt == 2'd2) begin
                d.e0 = q.e1;
                if (up.push) begin
                    d.e1 = up.din;
                end
            end else if (up.push) begin
                d.e0 = up.din;
            end
        end else if (up.push) begin
            if (q.cnt == 2'd0) begin
                d.e0 = up.din;
            end else begin
                d.e1 = up.din;
            end
        end
        d.cnt = q.cnt + {1'b0, up.push} - {1'b0, pop};
        d.vld = (d.cnt != 2'd0);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Room is judged on the next count, so the writer may register it
    assign up.room = (d.cnt <= 2'd1);
    assign up.empty = !q.vld;
    assign out_valid = q.vld;
    assign out_data = q.e0;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_buf_no_overflow: assert property (
        up.push && q.cnt == 2'd2 |-> out_ready)
        else $error("word pushed into full buffer");

    a_buf_hold_head: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled head word changed");

endmodule

// ==== lwc_dir_mem.sv ====
`timescale 1ns/100ps
module lwc_dir_mem import lwc_pkg::*; #(
    parameter int AW = DIR_AW,
    parameter int DW = DIR_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    lwc_dir_if.mem port
);

    typedef struct packed {
        logic [(1 << AW)-1:0][DW-1:0] arr;
        logic [DW-1:0] rd;
    } lwc_mem_s;

    lwc_mem_s q;
    lwc_mem_s d;

    if (AW < 1 || AW > 8) begin : g_chk
        $error("lwc_dir_mem: address width out of range");
    end

    // ------------------------------------------------------------
    // Directory store, registered read of old contents
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rd = q.arr[port.raddr];
        if (port.we) begin
            d.arr[port.waddr] = port.wdata;
        end
    end

    // Cleared directory means every log aborts until it is loaded
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign port.rdata = q.rd;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_dir_write_lands: assert property (
        port.we |=> q.arr[$past(port.waddr)] == $past(port.wdata))
        else $error("directory write lost");

endmodule

// ==== lwc_top.sv ====
`timescale 1ns/100ps
module lwc_top import lwc_pkg::*; #(
    parameter int BLK_SECTORS = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cnt_cur,
    input wire logic [7:0] cnt_prev,
    input wire logic [7:0] log_sel,
    input wire logic [7:0] first_cur,
    input wire logic [7:0] first_prev,
    input wire logic wd_valid,
    input wire logic [DATA_W-1:0] wd_data,
    output logic wd_ready,
    output logic st_valid,
    output logic [ST_W-1:0] st_data,
    input wire logic st_ready,
    input wire logic dir_wr,
    input wire logic [DIR_AW-1:0] dir_addr,
    input wire logic [DIR_W-1:0] dir_entry,
    output logic [7:0] command_error_report,
    output logic [7:0] command_completion_state,
    output logic drq,
    output logic dma_mode,
    output logic intrq
);

    typedef struct packed {
        lwc_state_e st;
        logic dma;
        logic [LOG_W-1:0] log;
        logic [15:0] cnt;
        logic [SEC_W-1:0] first;
        logic [SEC_W-1:0] sec;
        logic [15:0] left;
        logic [WIDX_W-1:0] widx;
        logic [15:0] blk;
        logic wrdy;
        logic irq;
        logic [7:0] err;
        logic [7:0] stat;
    } lwc_top_s;

    localparam logic [15:0] BLK_LAST = 16'(BLK_SECTORS - 1);
    localparam logic [WIDX_W-1:0] WIDX_LAST = WIDX_W'(WORDS_PER_SECTOR - 1);

    lwc_top_s q;
    lwc_top_s d;
    logic take;
    logic sec_end;
    logic blk_end;
    logic [DIR_SIZE_W-1:0] dir_size;
    logic dir_ro;
    logic dir_feat;
    logic [16:0] span;
    logic abort_any;

    if (BLK_SECTORS < 1 || BLK_SECTORS > 65535) begin : g_chk
        $error("lwc_top: block size out of range");
    end

    lwc_strm_if #(.W(ST_W)) strm ();
    lwc_dir_if #(.AW(DIR_AW), .DW(DIR_W)) dir ();

    // ------------------------------------------------------------
    // Directory and store buffer
    // ------------------------------------------------------------
    lwc_dir_mem #(.AW(DIR_AW), .DW(DIR_W)) u_dir (
        .sys_clk(sys_clk),
        .rst(rst),
        .port(dir.mem)
    );

    lwc_buf #(.W(ST_W)) u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .up(strm.snk),
        .out_valid(st_valid),
        .out_data(st_data),
        .out_ready(st_ready)
    );

    assign dir.we = dir_wr;
    assign dir.waddr = dir_addr;
    assign dir.wdata = dir_entry;
    assign dir.raddr = q.log;

    assign strm.push = take;
    assign strm.din = {q.log, q.sec, q.widx, wd_data};

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.irq = 1'b0;
        take = q.wrdy && wd_valid;
        sec_end = take && (q.widx == WIDX_LAST);
        blk_end = sec_end && (q.blk == BLK_LAST || q.left == 16'd1);
        dir_size = dir.rdata[DIR_SIZE_W-1:0];
        dir_ro = dir.rdata[DIR_RO_BIT];
        dir_feat = dir.rdata[DIR_FEAT_BIT];
        span = {1'b0, q.first} + {1'b0, q.cnt};
        abort_any = (q.cnt > dir_size) || dir_ro || !dir_feat || (q.cnt == 16'd0)
            || (span > {1'b0, dir_size});
        case (q.st)
            S_IDLE: begin
                if (cmd_wr && (cmd_code == OP_LOG_PIO || cmd_code == OP_LOG_DMA)) begin
                    d.dma = (cmd_code == OP_LOG_DMA);
                    d.cnt = {cnt_prev, cnt_cur};
                    d.log = log_sel;
                    d.first = {first_prev, first_cur};
                    d.err = ERR_RESET;
                    d.stat = lwc_stat(1'b1, 1'b0, 1'b0);
                    d.st = S_LOOK;
                end
            end
            S_LOOK: begin
                d.st = S_CHECK;
            end
            S_CHECK: begin
                if (abort_any) begin
                    d.err[ER_ABT] = 1'b1;
                    d.stat = lwc_stat(1'b0, 1'b0, 1'b1);
                    d.irq = 1'b1;
                    d.st = S_IDLE;
                end else begin
                    d.sec = q.first;
                    d.left = q.cnt;
                    d.widx = '0;
                    d.blk = 16'd0;
                    d.stat = lwc_stat(1'b1, 1'b1, 1'b0);
                    d.st = S_XFER;
                end
            end
            S_XFER: begin
                if (take) begin
                    d.widx = q.widx + WIDX_W'(1);
                end
                if (sec_end) begin
                    d.sec = q.sec + 16'd1;
                    d.left = q.left - 16'd1;
                    d.blk = blk_end ? 16'd0 : q.blk + 16'd1;
                end
                // Block interrupt, last one left to completion
                if (blk_end && !q.dma && q.left != 16'd1) begin
                    d.irq = 1'b1;
                end
                if (sec_end && q.left == 16'd1) begin
                    d.stat = lwc_stat(1'b1, 1'b0, 1'b0);
                    d.st = S_FIN;
                end
            end
            S_FIN: begin
                // Report only once every word left the buffer
                if (strm.empty) begin
                    d.stat = lwc_stat(1'b0, 1'b0, 1'b0);
                    d.irq = 1'b1;
                    d.st = S_IDLE;
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase
        // Registered ready relies on the buffer's next-cycle room
        d.wrdy = (d.st == S_XFER) && strm.room;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
            q.stat <= STAT_RESET;
        end else begin
            q <= d;
        end
    end

    assign wd_ready = q.wrdy;
    assign command_error_report = q.err;
    assign command_completion_state = q.stat;
    assign drq = q.stat[ST_DRQ];
    assign dma_mode = q.dma;
    assign intrq = q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_accept;
        q.st == S_IDLE && cmd_wr && (cmd_code == OP_LOG_PIO || cmd_code == OP_LOG_DMA);
    endsequence

    sequence s_lookup;
        q.stat[ST_BSY] && q.st == S_LOOK ##1 q.st == S_CHECK;
    endsequence

    a_cmd_accept: assert property (s_accept |=> s_lookup)
        else $error("command not taken into lookup");

    a_dma_mode_set: assert property (
        s_accept and (cmd_code == OP_LOG_DMA) |=> q.dma ##1 q.dma)
        else $error("dma form not recorded");

    a_dma_no_block_irq: assert property (
        q.dma && q.st == S_XFER |-> !q.irq)
        else $error("dma form raised block interrupt");

    a_sector_words: assert property (
        q.st == S_XFER && sec_end |=> q.widx == '0 && q.sec == $past(q.sec) + 16'd1)
        else $error("sector did not close after 256 words");

    a_pio_block_irq: assert property (
        q.st == S_XFER && blk_end && !q.dma && q.left != 16'd1 |=> q.irq)
        else $error("missing block interrupt");

    a_size_abort: assert property (
        q.st == S_CHECK && q.cnt > dir_size |=> q.err[ER_ABT] && q.st == S_IDLE)
        else $error("oversize count not aborted");

    a_start_sector: assert property (
        q.st == S_CHECK && !abort_any |=> q.sec == $past(q.first) && q.stat[ST_DRQ])
        else $error("store did not start at first sector");

    a_ro_abort: assert property (
        q.st == S_CHECK && dir_ro |=> q.err[ER_ABT] ##1 q.st == S_IDLE)
        else $error("read-only log not aborted");

    a_feat_abort: assert property (
        q.st == S_CHECK && !dir_feat |=> q.err[ER_ABT])
        else $error("disabled log not aborted");

    a_zero_abort: assert property (
        q.st == S_CHECK && q.cnt == 16'd0 |=> q.err[ER_ABT] && q.stat[ST_ERR])
        else $error("zero count not aborted");

    a_abort_report: assert property (
        q.st == S_CHECK && abort_any
        |=> q.err[ER_ABT] && q.stat[ST_ERR] && !q.stat[ST_BSY] && q.irq)
        else $error("abort report incomplete");

    a_done_status: assert property (
        q.st == S_FIN && strm.empty
        |=> !q.stat[ST_BSY] && !q.stat[ST_DF] && !q.stat[ST_COR] && q.stat[ST_RDY]
            && q.stat[ST_DSC] && !q.stat[ST_ERR] && q.irq)
        else $error("completion status wrong");

endmodule

// ==== lwc_host_model.sv ====
`timescale 1ns/100ps
module lwc_host_model import lwc_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic drq_in,
    input wire logic stall_en,
    input wire logic wd_ready,
    output logic wd_valid,
    output logic [DATA_W-1:0] wd_data,
    output logic st_ready
);
    // ------------------------------------------------------------
    // Host data source and storage sink
    // ------------------------------------------------------------
    logic [15:0] n_q;
    logic [1:0] ph_q;
    logic [15:0] nxt;

    assign nxt = (wd_valid && wd_ready) ? n_q + 16'h0001 : n_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            n_q <= 16'h0000;
            ph_q <= 2'h0;
            wd_valid <= 1'b0;
            wd_data <= 16'hffff;
            st_ready <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            n_q <= nxt;
            // Slow sink takes one word in four, so the buffer fills
            st_ready <= !stall_en || (ph_q == 2'h3);
            wd_valid <= drq_in;
            // Released bus shows the inverse, never a stale word
            wd_data <= drq_in ? 16'h1000 + nxt : ~(16'h1000 + nxt);
        end
    end
endmodule

// ==== test_lwc_top.sv ====
`timescale 1ns/100ps
module test_lwc_top;
    import lwc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_wr = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] cnt_cur = 8'h00;
    logic [7:0] cnt_prev = 8'h00;
    logic [7:0] log_sel = 8'h00;
    logic [7:0] first_cur = 8'h00;
    logic [7:0] first_prev = 8'h00;
    logic dir_wr = 1'b0;
    logic [DIR_AW-1:0] dir_addr = 8'h00;
    logic [DIR_W-1:0] dir_entry = 18'h00000;
    logic stall_en = 1'b0;
    logic wd_valid, wd_ready, st_valid, st_ready, drq, dma_mode, intrq;
    logic [DATA_W-1:0] wd_data;
    logic [ST_W-1:0] st_data;
    logic [7:0] err_reg, stat_reg;
    logic [7:0] exp_log = 8'h00;
    logic [15:0] exp_first = 16'h0000;
    int fail_count = 0;
    int n_checks = 0;
    int irq_cnt = 0;
    int rx_cmd = 0;
    int rx_total = 0;
    int refuse_cnt = 0;

    always #25 sys_clk = ~sys_clk;

    lwc_top #(.BLK_SECTORS(1)) dut (.sys_clk(sys_clk), .rst(rst), .cmd_wr(cmd_wr),
        .cmd_code(cmd_code), .cnt_cur(cnt_cur), .cnt_prev(cnt_prev), .log_sel(log_sel),
        .first_cur(first_cur), .first_prev(first_prev), .wd_valid(wd_valid),
        .wd_data(wd_data), .wd_ready(wd_ready), .st_valid(st_valid), .st_data(st_data),
        .st_ready(st_ready), .dir_wr(dir_wr), .dir_addr(dir_addr), .dir_entry(dir_entry),
        .command_error_report(err_reg), .command_completion_state(stat_reg), .drq(drq),
        .dma_mode(dma_mode), .intrq(intrq));

    lwc_host_model host (.sys_clk(sys_clk), .rst(rst), .drq_in(drq), .stall_en(stall_en),
        .wd_ready(wd_ready), .wd_valid(wd_valid), .wd_data(wd_data), .st_ready(st_ready));

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_reg(input string name, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_word(input string name, input logic [47:0] e, input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_cnt(input string name, input int e, input int g);
        n_checks++;
        if (g != e) begin
            fail_count++;
            $display("ERROR %s expected %0d seen %0d", name, e, g);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor of stored words and interrupts
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (intrq === 1'b1) irq_cnt++;
        if (drq === 1'b1 && wd_valid === 1'b1 && wd_ready === 1'b0) refuse_cnt++;
        if (!rst && st_valid === 1'b1 && st_ready === 1'b1) begin
            chk_word("store word", {exp_log, exp_first + 16'(rx_cmd / 256), 8'(rx_cmd % 256),
                16'h1000 + 16'(rx_total)}, st_data);
            rx_cmd++;
            rx_total++;
        end
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic dir_load(input logic [7:0] a, input logic [15:0] size, input logic ro,
        input logic feat);
        @(posedge sys_clk);
        dir_wr <= 1'b1;
        dir_addr <= a;
        dir_entry <= {feat, ro, size};
        @(posedge sys_clk);
        dir_wr <= 1'b0;
    endtask

    // Returns one ns after the second edge past the taking edge
    task automatic issue(input logic [7:0] op, input logic [7:0] lg, input logic [15:0] cnt,
        input logic [15:0] first, input logic slow);
        @(posedge sys_clk);
        cmd_wr <= 1'b1;
        cmd_code <= op;
        stall_en <= slow;
        cnt_cur <= cnt[7:0];
        cnt_prev <= cnt[15:8];
        log_sel <= lg;
        {first_prev, first_cur} <= first;
        exp_log = lg;
        exp_first = first;
        rx_cmd = 0;
        irq_cnt = 0;
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic run_abort(input logic [7:0] op, input logic [7:0] lg,
        input logic [15:0] cnt, input logic [15:0] first);
        issue(op, lg, cnt, first, 1'b0);
        chk_reg("error", 8'h04, err_reg);
        chk_reg("status", 8'h51, stat_reg);
        chk_reg("intrq", 8'h01, {7'h00, intrq});
        // Let the pulse be counted before the next command clears the count
        @(posedge sys_clk);
        #1;
        chk_reg("intrq end", 8'h00, {7'h00, intrq});
    endtask

    task automatic run_pass(input logic [7:0] op, input logic [15:0] cnt,
        input logic [15:0] first, input logic slow, input int exp_irq);
        int i;
        issue(op, 8'h80, cnt, first, slow);
        chk_reg("status", 8'h88, stat_reg);
        chk_reg("mode", {7'h00, op == OP_LOG_DMA}, {7'h00, dma_mode});
        i = 0;
        while (stat_reg !== 8'h50 && i < 20000) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        if (i >= 20000) begin
            fail_count++;
            print_verdict();
        end
        repeat (3) @(posedge sys_clk);
        #1;
        chk_reg("status", 8'h50, stat_reg);
        chk_reg("error", 8'h00, err_reg);
        chk_reg("drq", 8'h00, {7'h00, drq});
        chk_cnt("words", int'(cnt) * 256, rx_cmd);
        chk_cnt("interrupts", exp_irq, irq_cnt);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_reg("status", STAT_RESET, stat_reg);
        chk_reg("error", ERR_RESET, err_reg);
        chk_reg("idle outputs", 8'h00, {4'h0, drq, intrq, wd_ready, st_valid});
        // Empty directory: every log reads as unsupported
        run_abort(OP_LOG_PIO, 8'h80, 16'h0001, 16'h0000);
        dir_load(8'h80, 16'h0004, 1'b0, 1'b1);
        dir_load(8'h81, 16'h0004, 1'b1, 1'b1);
        dir_load(8'h82, 16'h0004, 1'b0, 1'b0);
        run_abort(OP_LOG_PIO, 8'h81, 16'h0001, 16'h0000);
        run_abort(OP_LOG_DMA, 8'h82, 16'h0001, 16'h0000);
        run_abort(OP_LOG_PIO, 8'h80, 16'h0005, 16'h0000);
        run_abort(OP_LOG_DMA, 8'h80, 16'h0100, 16'h0000);
        run_abort(OP_LOG_DMA, 8'h80, 16'h0000, 16'h0000);
        run_abort(OP_LOG_PIO, 8'h80, 16'h0004, 16'h0001);
        // Unknown opcode leaves the previous outcome standing
        issue(8'hc5, 8'h80, 16'h0001, 16'h0000, 1'b0);
        chk_reg("status", 8'h51, stat_reg);
        chk_cnt("interrupts", 0, irq_cnt);
        run_pass(OP_LOG_PIO, 16'h0002, 16'h0002, 1'b1, 2);
        chk_cnt("buffer refusals", 1, (refuse_cnt > 0) ? 1 : 0);
        run_pass(OP_LOG_DMA, 16'h0004, 16'h0000, 1'b0, 1);
        run_pass(OP_LOG_PIO, 16'h0001, 16'h0003, 1'b0, 1);
        print_verdict();
    end
endmodule
